// ==== logic/sadc_pkg.sv ====
// constants, types and timing table of the sar converter sequencer
package sadc_pkg;

  // ***********************************************************
  // register map (byte addresses, one word each)
  // ***********************************************************
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CHAN = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_UPPER = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;

  // ***********************************************************
  // field positions and reset values
  // ***********************************************************
  localparam int MODE_RUN_POS = 7;
  localparam int MODE_CODE_LSB = 3;
  localparam int MODE_AFE_POS = 0;
  localparam int IRQ_DONE_POS = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [0:0] IRQ_RESET = 1'h0;
  localparam logic [9:0] SAR_MSB = 10'h200;
  localparam logic [3:0] SAR_MSB_IDX = 4'h9;
  localparam logic [7:0] BITS_PER_RESULT = 8'h0a;

  // ***********************************************************
  // timing counts in peripheral clocks
  // ***********************************************************
  localparam logic [7:0] START_WAIT = 8'h01;
  localparam logic [7:0] SAMP_C0 = 8'h0c;
  localparam logic [7:0] TOTAL_C0 = 8'h24;
  localparam logic [7:0] SAMP_C1 = 8'h18;
  localparam logic [7:0] TOTAL_C1 = 8'h30;
  localparam logic [7:0] SAMP_C2 = 8'h30;
  localparam logic [7:0] TOTAL_C2 = 8'h48;
  localparam logic [7:0] SAMP_C3 = 8'h58;
  localparam logic [7:0] TOTAL_C3 = 8'h70;
  localparam logic [7:0] SAMP_C4 = 8'h18;
  localparam logic [7:0] TOTAL_C4 = 8'h48;
  localparam logic [7:0] SAMP_C5 = 8'h30;
  localparam logic [7:0] TOTAL_C5 = 8'h60;
  localparam logic [7:0] SAMP_C6 = 8'h60;
  localparam logic [7:0] TOTAL_C6 = 8'h90;
  localparam logic [7:0] SAMP_C7 = 8'hb0;
  localparam logic [7:0] TOTAL_C7 = 8'he0;

  typedef struct packed {
    logic [7:0] samp;
    logic [7:0] conv;
    logic [7:0] step;
  } sadc_timing_s;

  typedef struct packed {
    logic sample;
    logic [1:0] chan;
    logic [9:0] dac;
    logic enable;
  } sadc_afe_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_SAMPLE = 2'b11,
    ST_CONV = 2'b10
  } sadc_state_e;

  function automatic sadc_timing_s sadc_mk(input logic [7:0] samp, input logic [7:0] total);
    sadc_timing_s t;
    t.samp = samp;
    t.conv = total - samp;
    t.step = t.conv / BITS_PER_RESULT;
    return t;
  endfunction

  function automatic sadc_timing_s sadc_timing(input logic [2:0] code);
    sadc_timing_s t;
    case (code)
      3'h0: t = sadc_mk(SAMP_C0, TOTAL_C0);
      3'h1: t = sadc_mk(SAMP_C1, TOTAL_C1);
      3'h2: t = sadc_mk(SAMP_C2, TOTAL_C2);
      3'h3: t = sadc_mk(SAMP_C3, TOTAL_C3);
      3'h4: t = sadc_mk(SAMP_C4, TOTAL_C4);
      3'h5: t = sadc_mk(SAMP_C5, TOTAL_C5);
      3'h6: t = sadc_mk(SAMP_C6, TOTAL_C6);
      default: t = sadc_mk(SAMP_C7, TOTAL_C7);
    endcase
    return t;
  endfunction

endpackage

// ==== logic/sadc_sequencer.sv ====
// sar converter sequencer with apb registers and interrupt
// ***********************************************************
// Summary of operation
// - convert selected channel repeatedly while running
// - one done interrupt per finished conversion
// - sampling starts 2-3 clocks after run
// - timing code picks sample and total lengths
// - total period covers sampling plus comparison
// - all counts in peripheral clock cycles
// - four channels chosen by channel register
// - unselected pins stay ordinary port pins
// - sample at start, hold during comparison
// - decide bits from msb down to lsb
// - copy approximation into result after lsb
// - full result right aligned, upper zero
// - upper result holds top eight bits
// - reset clears mode register, conversion stopped
// ***********************************************************
`timescale 1ns/100ps

module sadc_sequencer (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic cmp_i,
  output sadc_pkg::sadc_afe_s afe_o,
  output logic [3:0] pin_analog_o,
  output logic irq_o
);

  // ***********************************************************
  // registers
  // ***********************************************************
  logic [7:0] mode;
  logic [1:0] chan;
  logic [9:0] result;
  logic [7:0] upper;
  logic [0:0] irq_stat;
  logic [0:0] irq_en;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic run;
  logic [2:0] code;
  logic lsb_done;

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_setup = psel_i && !penable_i;
  assign run = mode[sadc_pkg::MODE_RUN_POS];
  assign code = mode[sadc_pkg::MODE_CODE_LSB +: 3];
  assign pready_o = 1'b1;

  always_comb begin
    case (paddr_i)
      sadc_pkg::ADDR_MODE,
      sadc_pkg::ADDR_CHAN,
      sadc_pkg::ADDR_RESULT,
      sadc_pkg::ADDR_UPPER,
      sadc_pkg::ADDR_IRQ_STAT,
      sadc_pkg::ADDR_IRQ_CLR,
      sadc_pkg::ADDR_IRQ_EN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // reserved mode bits are dropped so they always read zero
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode <= sadc_pkg::MODE_RESET;
    end else if (ce_i && wr_en && paddr_i == sadc_pkg::ADDR_MODE) begin
      mode <= pwdata_i[7:0] & 8'hb9;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chan <= sadc_pkg::CHAN_RESET;
    end else if (ce_i && wr_en && paddr_i == sadc_pkg::ADDR_CHAN) begin
      chan <= pwdata_i[1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_en <= sadc_pkg::IRQ_RESET;
    end else if (ce_i && wr_en && paddr_i == sadc_pkg::ADDR_IRQ_EN) begin
      irq_en <= pwdata_i[sadc_pkg::IRQ_DONE_POS +: 1];
    end
  end

  // set wins over a clear landing in the same cycle
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat <= sadc_pkg::IRQ_RESET;
    end else if (ce_i) begin
      if (lsb_done) begin
        irq_stat <= 1'b1;
      end else if (wr_en && paddr_i == sadc_pkg::ADDR_IRQ_CLR
                   && pwdata_i[sadc_pkg::IRQ_DONE_POS]) begin
        irq_stat <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(irq_stat & irq_en);
    end
  end

  // read data captured in setup, so pready can stay high
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (ce_i && rd_setup) begin
      pslverr_o <= !mapped;
      case (paddr_i)
        sadc_pkg::ADDR_MODE: prdata_o <= {24'h000000, mode};
        sadc_pkg::ADDR_CHAN: prdata_o <= {30'h00000000, chan};
        sadc_pkg::ADDR_RESULT: prdata_o <= {22'h000000, result};
        sadc_pkg::ADDR_UPPER: prdata_o <= {24'h000000, upper};
        sadc_pkg::ADDR_IRQ_STAT: prdata_o <= {31'h00000000, irq_stat};
        sadc_pkg::ADDR_IRQ_EN: prdata_o <= {31'h00000000, irq_en};
        default: prdata_o <= 32'h00000000;
      endcase
    end
  end

  // ***********************************************************
  // comparator capture
  // ***********************************************************
  // latched comparator runs on mclk: one stage only, two would miss 2-clock steps
  logic cmp_s;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmp_s <= 1'b0;
    end else if (ce_i) begin
      cmp_s <= cmp_i;
    end
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************
  sadc_pkg::sadc_state_e state;
  sadc_pkg::sadc_timing_s tim_sel;
  sadc_pkg::sadc_timing_s cur_tim;
  logic [7:0] cnt;
  logic [7:0] step_cnt;
  logic [7:0] window;
  logic [3:0] bit_idx;
  logic [9:0] sar;
  logic [9:0] next_sar;
  logic [1:0] chan_lat;
  logic in_window;
  logic decide;

  assign tim_sel = sadc_pkg::sadc_timing(code);
  assign window = 8'(cur_tim.step * sadc_pkg::BITS_PER_RESULT);
  assign in_window = cnt < window;
  // each decision reads the capture of the trial set one step earlier
  assign decide = state == sadc_pkg::ST_CONV && in_window && step_cnt == 8'h00;
  assign lsb_done = run && state == sadc_pkg::ST_CONV && cnt == 8'h00;

  always_comb begin
    next_sar = sar;
    if (!cmp_s) begin
      next_sar[bit_idx] = 1'b0;
    end
    if (bit_idx != 4'h0) begin
      next_sar[bit_idx - 4'h1] = 1'b1;
    end
  end

  // counts reload at each sampling start, so a code change hits the next conversion
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= sadc_pkg::ST_IDLE;
      cnt <= 8'h00;
      step_cnt <= 8'h00;
      bit_idx <= 4'h0;
      sar <= 10'h000;
      cur_tim <= '0;
      chan_lat <= sadc_pkg::CHAN_RESET;
    end else if (ce_i) begin
      if (!run) begin
        state <= sadc_pkg::ST_IDLE;
      end else begin
        case (state)
          sadc_pkg::ST_IDLE: begin
            state <= sadc_pkg::ST_WAIT;
            cnt <= sadc_pkg::START_WAIT;
          end
          sadc_pkg::ST_WAIT: begin
            if (cnt == 8'h00) begin
              state <= sadc_pkg::ST_SAMPLE;
              cnt <= tim_sel.samp - 8'h01;
              cur_tim <= tim_sel;
              chan_lat <= chan;
            end else begin
              cnt <= cnt - 8'h01;
            end
          end
          sadc_pkg::ST_SAMPLE: begin
            if (cnt == 8'h00) begin
              state <= sadc_pkg::ST_CONV;
              cnt <= cur_tim.conv - 8'h01;
              step_cnt <= cur_tim.step - 8'h01;
              bit_idx <= sadc_pkg::SAR_MSB_IDX;
              sar <= sadc_pkg::SAR_MSB;
            end else begin
              cnt <= cnt - 8'h01;
            end
          end
          sadc_pkg::ST_CONV: begin
            if (decide) begin
              sar <= next_sar;
              step_cnt <= cur_tim.step - 8'h01;
              if (bit_idx != 4'h0) begin
                bit_idx <= bit_idx - 4'h1;
              end
            end else if (in_window) begin
              step_cnt <= step_cnt - 8'h01;
            end
            if (cnt == 8'h00) begin
              state <= sadc_pkg::ST_SAMPLE;
              cnt <= tim_sel.samp - 8'h01;
              cur_tim <= tim_sel;
              chan_lat <= chan;
            end else begin
              cnt <= cnt - 8'h01;
            end
          end
          default: state <= sadc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // result stays readable after a stop
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result <= sadc_pkg::RESULT_RESET;
      upper <= 8'h00;
    end else if (ce_i && lsb_done) begin
      result <= next_sar;
      upper <= next_sar[9:2];
    end
  end

  // ***********************************************************
  // front end drive
  // ***********************************************************
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_analog_o <= 4'h0;
    end else if (ce_i) begin
      pin_analog_o <= 4'h1 << chan;
    end
  end

  always_comb begin
    afe_o.sample = state == sadc_pkg::ST_SAMPLE;
    afe_o.chan = chan_lat;
    afe_o.dac = sar;
    afe_o.enable = mode[sadc_pkg::MODE_AFE_POS];
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  logic [8:0] phase_len;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_len <= 9'h000;
    end else if (ce_i) begin
      // seeded in the first sampling cycle; counts up to the coming edge
      if (state == sadc_pkg::ST_SAMPLE && cnt == cur_tim.samp - 8'h01) begin
        phase_len <= 9'h002;
      end else if (state != sadc_pkg::ST_IDLE) begin
        phase_len <= phase_len + 9'h001;
      end
    end
  end

  start_delay_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i || !ce_i)
    $rose(run) && state == sadc_pkg::ST_IDLE |-> ##[2:3] state == sadc_pkg::ST_SAMPLE)
    else $error("sampling did not start in time");

  sample_len_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i || !ce_i)
    state == sadc_pkg::ST_SAMPLE ##1 state == sadc_pkg::ST_CONV
    |-> phase_len == {1'b0, cur_tim.samp} + 9'h001)
    else $error("sampling length wrong");

  total_len_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i || !ce_i)
    lsb_done |-> phase_len == {1'b0, cur_tim.samp} + {1'b0, cur_tim.conv})
    else $error("total conversion length wrong");

  done_irq_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i || !ce_i)
    lsb_done && irq_en[0] |-> ##1 irq_stat[0] ##1 irq_o)
    else $error("done did not raise interrupt");

  upper_match_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    upper == result[9:2])
    else $error("upper result out of step");

  hold_stable_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i || !ce_i)
    state == sadc_pkg::ST_CONV |-> !afe_o.sample && $stable(afe_o.chan))
    else $error("sample held badly during comparison");

  msb_first_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i || !ce_i)
    $rose(state == sadc_pkg::ST_CONV) |-> sar == sadc_pkg::SAR_MSB
    && bit_idx == sadc_pkg::SAR_MSB_IDX)
    else $error("approximation did not start at msb");

  stop_run_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i || !ce_i)
    !run |-> ##1 state == sadc_pkg::ST_IDLE && !lsb_done)
    else $error("sequencer kept running after stop");

  result_copy_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i || !ce_i)
    lsb_done |-> ##1 result == $past(next_sar))
    else $error("result not copied at lsb");

  pin_onehot_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $onehot0(pin_analog_o))
    else $error("more than one analog pin claimed");

endmodule

// ==== bench/sadc_afe_model.sv ====
// behavioural analog front end: sample-hold, dac and comparator
`timescale 1ns/100ps

module sadc_afe_model (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire sadc_pkg::sadc_afe_s afe_i,
  input wire logic [3:0][9:0] level_i,
  output logic cmp_o
);
  // ***********************************************************
  // sample-hold and comparator
  // ***********************************************************
  logic [9:0] held;

  // tracks the chosen pin only while sampling, frozen during comparison
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      held <= 10'h000;
    end else if (afe_i.sample) begin
      held <= level_i[afe_i.chan];
    end
  end

  // at or above the trial level keeps the bit, so a level converts to itself
  // ideal: needs no minimum sample or total time, nor clock margin
  assign cmp_o = (held >= afe_i.dac);
endmodule

// ==== bench/sar_adc_sequencer_tb.sv ====
// self-checking bench of the sar converter sequencer
`timescale 1ns/100ps

module sar_adc_sequencer_tb;
  // ***********************************************************
  // clock, reset and wiring
  // ***********************************************************
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cmp;
  logic irq;
  logic [3:0] pin_analog;
  sadc_pkg::sadc_afe_s afe;
  logic [3:0][9:0] level = {10'h3ff, 10'h2a5, 10'h000, 10'h155};
  int samp_len[8] = '{12, 24, 48, 88, 24, 48, 96, 176};
  int total_len[8] = '{36, 48, 72, 112, 72, 96, 144, 224};
  int n_fail = 0;
  int num_checks = 0;

  always #5 mclk = ~mclk;

  sadc_sequencer dut (.mclk_i(mclk), .arst_n_i(arst_n), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cmp_i(cmp),
    .afe_o(afe), .pin_analog_o(pin_analog), .irq_o(irq));

  sadc_afe_model afe_model (.mclk_i(mclk), .arst_n_i(arst_n), .afe_i(afe),
    .level_i(level), .cmp_o(cmp));

  // ***********************************************************
  // shared tasks
  // ***********************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic timeout;
    n_fail++;
    $display("BAD t=%0t wait ran out", $time);
    wrap_up();
  endtask

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  // request held until pready is seen at an edge; data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) timeout();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // cycles until the next rising edge of the sample strobe
  task automatic wait_rise(output int n);
    logic p;
    tick();
    p = afe.sample;
    for (n = 2; n <= 400; n++) begin
      tick();
      if (afe.sample === 1'b1 && p !== 1'b1) break;
      p = afe.sample;
    end
    if (n > 400) timeout();
  endtask

  // called just after a rise: sampling length and rise-to-rise period
  task automatic meas(output int s, output int t);
    t = 0;
    do begin
      tick();
      t++;
    end while (afe.sample === 1'b1 && t < 400);
    s = t;
    check(afe.dac, 32'h200);
    do begin
      tick();
      t++;
    end while (afe.sample !== 1'b1 && t < 400);
    if (t >= 400) timeout();
  endtask

  task automatic wait_irq;
    int k;
    for (k = 0; k < 400 && irq !== 1'b1; k++) tick();
    if (k == 400) timeout();
  endtask

  // ***********************************************************
  // scenarios
  // ***********************************************************
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    check(pin_analog, 32'h1);
    check(afe.sample, 32'h0);
    rd(sadc_pkg::ADDR_MODE, q);
    check(q, 32'h0);
    rd(sadc_pkg::ADDR_IRQ_STAT, q);
    check(q, 32'h0);
    apb(1'b0, 8'h1c, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    wr(sadc_pkg::ADDR_RESULT, 32'h3ff);
    rd(sadc_pkg::ADDR_RESULT, q);
    check(q, 32'h0);
    wr(sadc_pkg::ADDR_MODE, 32'h7f);
    rd(sadc_pkg::ADDR_MODE, q);
    check(q, 32'h39);
    check(afe.enable, 32'h1);
    check(afe.sample, 32'h0);
    wr(sadc_pkg::ADDR_MODE, 32'h0);
  endtask

  task automatic t_first;
    logic [31:0] q;
    int n;
    int s;
    int t;
    wr(sadc_pkg::ADDR_IRQ_EN, 32'h1);
    wr(sadc_pkg::ADDR_CHAN, 32'h2);
    wr(sadc_pkg::ADDR_MODE, 32'h80);
    wait_rise(n);
    check(n inside {2, 3}, 32'h1);
    check(afe.chan, 32'h2);
    meas(s, t);
    check(s, 32'd12);
    check(t, 32'd36);
    // irq follows the status bit one clock later
    tick();
    check(irq, 32'h1);
    rd(sadc_pkg::ADDR_RESULT, q);
    check(q, 32'h2a5);
    rd(sadc_pkg::ADDR_UPPER, q);
    check(q, 32'ha9);
    wr(sadc_pkg::ADDR_IRQ_CLR, 32'h1);
    tick();
    tick();
    check(irq, 32'h0);
  endtask

  task automatic t_codes;
    int c;
    int n;
    int s;
    int t;
    logic [31:0] q;
    for (c = 0; c < 8; c++) begin
      wr(sadc_pkg::ADDR_MODE, 32'h80 | (c << 3));
      rd(sadc_pkg::ADDR_MODE, q);
      check(q, 32'h80 | (c << 3));
      wait_rise(n);
      meas(s, t);
      check(s, samp_len[c]);
      check(t, total_len[c]);
    end
  endtask

  task automatic t_channels;
    int ch;
    int n;
    logic [31:0] q;
    wr(sadc_pkg::ADDR_MODE, 32'h80);
    for (ch = 0; ch < 4; ch++) begin
      wr(sadc_pkg::ADDR_CHAN, ch);
      tick();
      check(pin_analog, 32'h1 << ch);
      wait_rise(n);
      wr(sadc_pkg::ADDR_IRQ_CLR, 32'h1);
      tick();
      tick();
      check(irq, 32'h0);
      wait_irq();
      rd(sadc_pkg::ADDR_RESULT, q);
      check(q, level[ch]);
      rd(sadc_pkg::ADDR_UPPER, q);
      check(q, level[ch][9:2]);
    end
  endtask

  task automatic t_mask_stop;
    int n;
    int k;
    int hits;
    logic [31:0] q;
    wr(sadc_pkg::ADDR_IRQ_EN, 32'h0);
    wr(sadc_pkg::ADDR_IRQ_CLR, 32'h1);
    wait_rise(n);
    tick();
    check(irq, 32'h0);
    rd(sadc_pkg::ADDR_IRQ_STAT, q);
    check(q, 32'h1);
    wr(sadc_pkg::ADDR_MODE, 32'h0);
    wr(sadc_pkg::ADDR_IRQ_CLR, 32'h1);
    wr(sadc_pkg::ADDR_IRQ_EN, 32'h1);
    hits = 0;
    for (k = 0; k < 300; k++) begin
      tick();
      hits += (afe.sample === 1'b1 || irq === 1'b1);
    end
    check(hits, 32'h0);
    rd(sadc_pkg::ADDR_RESULT, q);
    check(q, 32'h3ff);
    wr(sadc_pkg::ADDR_MODE, 32'h80);
    wait_rise(n);
    check(n inside {2, 3}, 32'h1);
  endtask

  // a low enable must hold every output still in mid-conversion
  task automatic t_freeze;
    sadc_pkg::sadc_afe_s a;
    logic [4:0] o;
    int k;
    int hits;
    hits = 0;
    @(posedge mclk);
    ce <= 1'b0;
    tick();
    a = afe;
    o = {pin_analog, irq};
    for (k = 0; k < 40; k++) begin
      tick();
      hits += (afe !== a || {pin_analog, irq} !== o);
    end
    @(posedge mclk);
    ce <= 1'b1;
    check(hits, 32'h0);
    wait_irq();
    check(irq, 32'h1);
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    tick();
    t_reset();
    t_first();
    t_codes();
    t_channels();
    t_mask_stop();
    t_freeze();
    wrap_up();
  end
endmodule
